//--- design/serial_port.v
// Host serial port, time pulse and power modes of the receiver
`include "serial_port_regs.vh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module serial_port #(
    parameter BIT_CYCLES = `BIT_CYC,
    parameter PULSE_CYCLES = `PULSE_CYC,
    parameter PERIOD_CYCLES = `PERIOD_CYC,
    // Periodic intervals follow the pulse period unless set apart
    parameter ON_CYCLES = PERIOD_CYCLES,
    parameter OFF_CYCLES = PERIOD_CYCLES
) (
    input wire CLK,
    input wire RST_N,
    input wire MODULE_SERIAL_IN,
    output reg MODULE_SERIAL_OUT,
    input wire BACKUP_SUPPLY_IN,
    input wire EXTERNAL_EVENT_IN,
    input wire MSG_VALID,
    output wire MSG_READY,
    input wire [7:0] MSG_DATA,
    output wire RX_VALID,
    input wire RX_READY,
    output wire [7:0] RX_DATA,
    output reg TIME_PULSE_OUT,
    output reg [1:0] POWER_MODE,
    output wire OPERATING,
    output reg WARM_START
);
////////////////////////////////////////////////////////////////////////////
// Receive synchroniser: three flops, change taken when last two agree
reg [2:0] rx_sync_reg;
reg rx_line_reg;
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        rx_sync_reg <= 3'h7;
        rx_line_reg <= 1'b1;
    end
    else
    begin
        rx_sync_reg <= {rx_sync_reg[1:0], MODULE_SERIAL_IN};
        if (rx_sync_reg[2] == rx_sync_reg[1])
            rx_line_reg <= rx_sync_reg[2];
    end
end
////////////////////////////////////////////////////////////////////////////
// Receiver, sampling mid-bit
reg [15:0] rx_cnt_reg;
reg [3:0] rx_bit_reg;
reg [7:0] rx_shift_reg;
reg rx_busy_reg;
reg rx_done_reg;
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        rx_cnt_reg <= 16'h0000;
        rx_bit_reg <= 4'h0;
        rx_shift_reg <= 8'h00;
        rx_busy_reg <= 1'b0;
        rx_done_reg <= 1'b0;
    end
    else
    begin
        rx_done_reg <= 1'b0;
        if (!rx_busy_reg)
        begin
            if (!rx_line_reg)
            begin
                rx_busy_reg <= 1'b1;
                rx_cnt_reg <= BIT_CYCLES[15:0] / 16'h0002;
                rx_bit_reg <= 4'h0;
            end
        end
        else if (rx_cnt_reg != 16'h0000)
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
        else
        begin
            rx_cnt_reg <= BIT_CYCLES[15:0] - 16'h0001;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0)
            begin
                if (rx_line_reg)
                    rx_busy_reg <= 1'b0; // False start, ignored
            end
            else if (rx_bit_reg <= 4'h8)
                rx_shift_reg <= {rx_line_reg, rx_shift_reg[7:1]};
            else
            begin
                rx_busy_reg <= 1'b0;
                // Bad stop bit drops the character
                rx_done_reg <= rx_line_reg;
            end
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// Two-entry buffer toward the receiving user; a full buffer drops a byte
reg [7:0] buf_mem_reg [0:1];
reg buf_wp_reg;
reg buf_rp_reg;
reg [1:0] buf_cnt_reg;
wire buf_push = rx_done_reg && (buf_cnt_reg != 2'd2);
wire buf_pop = RX_VALID && RX_READY;
assign RX_VALID = (buf_cnt_reg != 2'd0);
assign RX_DATA = buf_mem_reg[buf_rp_reg];
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        buf_mem_reg[0] <= 8'h00;
        buf_mem_reg[1] <= 8'h00;
        buf_wp_reg <= 1'b0;
        buf_rp_reg <= 1'b0;
        buf_cnt_reg <= 2'd0;
    end
    else
    begin
        if (buf_push)
        begin
            buf_mem_reg[buf_wp_reg] <= rx_shift_reg;
            buf_wp_reg <= ~buf_wp_reg;
        end
        if (buf_pop)
            buf_rp_reg <= ~buf_rp_reg;
        buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
end
////////////////////////////////////////////////////////////////////////////
// Power modes driven by received command bytes
reg [31:0] per_cnt_reg;
reg per_on_reg;
reg [31:0] on_len_reg;
reg [31:0] off_len_reg;
assign OPERATING = (POWER_MODE == `MODE_NORMAL) ||
    (POWER_MODE[1] && per_on_reg);
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        POWER_MODE <= `MODE_NORMAL;
        per_cnt_reg <= 32'h0;
        per_on_reg <= 1'b1;
        on_len_reg <= 32'h0;
        off_len_reg <= 32'h0;
    end
    else
    begin
        if (rx_done_reg)
        begin
            if (POWER_MODE == `MODE_STANDBY)
                POWER_MODE <= `MODE_NORMAL;
            else
            begin
                case (rx_shift_reg)
                    `CMD_STANDBY: POWER_MODE <= `MODE_STANDBY;
                    `CMD_PERIODIC: POWER_MODE <= `MODE_PERIODIC;
                    `CMD_ADAPTIVE: POWER_MODE <= `MODE_ADAPTIVE;
                    `CMD_NORMAL: POWER_MODE <= `MODE_NORMAL;
                    default: POWER_MODE <= POWER_MODE;
                endcase
                per_cnt_reg <= 32'h0;
                per_on_reg <= 1'b1;
                on_len_reg <= ON_CYCLES;
                off_len_reg <= OFF_CYCLES;
            end
        end
        else if (POWER_MODE[1])
        begin
            if (per_cnt_reg + 32'h1 >= (per_on_reg ? on_len_reg : off_len_reg))
            begin
                per_cnt_reg <= 32'h0;
                per_on_reg <= ~per_on_reg;
                // Adaptive: longer rest while the host stays quiet
                if (POWER_MODE == `MODE_ADAPTIVE && !per_on_reg &&
                    off_len_reg < (OFF_CYCLES << 2))
                    off_len_reg <= off_len_reg << 1;
            end
            else
                per_cnt_reg <= per_cnt_reg + 32'h1;
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// Start kind caught once after reset release; event input is not used
reg start_seen_reg;
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        start_seen_reg <= 1'b0;
        WARM_START <= 1'b0;
    end
    else if (!start_seen_reg)
    begin
        start_seen_reg <= 1'b1;
        WARM_START <= BACKUP_SUPPLY_IN;
    end
end
////////////////////////////////////////////////////////////////////////////
// Time pulse, only while operating
reg [31:0] tp_cnt_reg;
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        tp_cnt_reg <= 32'h0;
        TIME_PULSE_OUT <= 1'b0;
    end
    else if (!OPERATING)
    begin
        tp_cnt_reg <= 32'h0;
        TIME_PULSE_OUT <= 1'b0;
    end
    else
    begin
        tp_cnt_reg <= (tp_cnt_reg + 32'h1 >= PERIOD_CYCLES) ? 32'h0 :
            tp_cnt_reg + 32'h1;
        TIME_PULSE_OUT <= (tp_cnt_reg < PULSE_CYCLES);
    end
end
////////////////////////////////////////////////////////////////////////////
// Transmitter: message bytes sent whole, only while operating
reg [15:0] tx_cnt_reg;
reg [3:0] tx_bit_reg;
reg [9:0] tx_shift_reg;
reg tx_busy_reg;
assign MSG_READY = !tx_busy_reg && OPERATING;
always @(posedge CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        tx_cnt_reg <= 16'h0000;
        tx_bit_reg <= 4'h0;
        tx_shift_reg <= 10'h3ff;
        tx_busy_reg <= 1'b0;
        MODULE_SERIAL_OUT <= 1'b1;
    end
    else if (!tx_busy_reg)
    begin
        MODULE_SERIAL_OUT <= 1'b1;
        if (MSG_VALID && MSG_READY)
        begin
            tx_shift_reg <= {1'b1, MSG_DATA, 1'b0};
            tx_busy_reg <= 1'b1;
            tx_cnt_reg <= 16'h0000;
            tx_bit_reg <= 4'h0;
        end
    end
    else if (tx_cnt_reg == 16'h0000)
    begin
        MODULE_SERIAL_OUT <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_cnt_reg <= BIT_CYCLES[15:0] - 16'h0001;
        tx_bit_reg <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == 4'ha)
            tx_busy_reg <= 1'b0;
    end
    else
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
end
endmodule
`default_nettype wire

//--- design/serial_port_regs.vh
// Constants for the receiver host serial port
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define CLK_HZ 20000000
`define BAUD_DEFAULT 9600
`define DATA_BITS 8
`define STOP_BITS 1
`define PULSE_MS 100
`define PULSE_PERIOD_MS 1000
`define PULSE_CYC ((`CLK_HZ / 1000) * `PULSE_MS)
`define PERIOD_CYC ((`CLK_HZ / 1000) * `PULSE_PERIOD_MS)
`define BIT_CYC (`CLK_HZ / `BAUD_DEFAULT)
`define CMD_STANDBY 8'h01
`define CMD_PERIODIC 8'h02
`define CMD_ADAPTIVE 8'h03
`define CMD_NORMAL 8'h04
`define MODE_NORMAL 2'd0
`define MODE_STANDBY 2'd1
`define MODE_PERIODIC 2'd2
`define MODE_ADAPTIVE 2'd3
`endif

//--- verif/serial_port_chk.sv
// Port-level checker for the host serial port
`default_nettype none
module serial_port_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic MODULE_SERIAL_OUT,
    input wire logic BACKUP_SUPPLY_IN,
    input wire logic MSG_VALID,
    input wire logic MSG_READY,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic [7:0] RX_DATA,
    input wire logic [1:0] POWER_MODE,
    input wire logic OPERATING,
    input wire logic WARM_START
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_start_low: assert property (
        MSG_VALID && MSG_READY |=> ##1 !MODULE_SERIAL_OUT [*8])
        else $error("start bit not low");
    a_stop_high: assert property (
        $rose(MSG_READY) |-> MODULE_SERIAL_OUT && $past(MODULE_SERIAL_OUT))
        else $error("no stop bit before ready");
    a_ready_needs_op: assert property (
        POWER_MODE == 2'h1 |-> !MSG_READY)
        else $error("ready while not operating");
    a_standby_idle: assert property (
        POWER_MODE == 2'h1 |-> !OPERATING)
        else $error("operating in standby");
    a_normal_runs: assert property (
        POWER_MODE == 2'h0 |-> OPERATING)
        else $error("normal mode not operating");
    a_warm_load: assert property (
        !$past(RST_N) |=> WARM_START == $past(BACKUP_SUPPLY_IN))
        else $error("start kind not loaded");
    a_rx_hold: assert property (
        RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
        else $error("received byte lost");
    a_wake_up: assert property (
        (POWER_MODE == 2'h1 && !RX_VALID) ##1 RX_VALID |->
        ##[0:2] POWER_MODE == 2'h0)
        else $error("byte did not wake");
endmodule
////////////////////////////////////////////////////////////////////////////
bind serial_port serial_port_chk i_chk (.CLK(CLK), .RST_N(RST_N),
    .MODULE_SERIAL_OUT(MODULE_SERIAL_OUT),
    .BACKUP_SUPPLY_IN(BACKUP_SUPPLY_IN), .MSG_VALID(MSG_VALID),
    .MSG_READY(MSG_READY), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_DATA(RX_DATA), .POWER_MODE(POWER_MODE), .OPERATING(OPERATING),
    .WARM_START(WARM_START));
`default_nettype wire

//--- verif/host_uart.sv
// Host serial controller model facing the receiver
`default_nettype none
module host_uart #(parameter int BIT = 16) (
    input wire logic clk,
    input wire logic rx,
    output logic tx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    logic [7:0] sh;
    // Pulled-up line rests high between characters
    initial tx = 1'h1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            tx <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask
    // Mid-bit sampling tolerates a few cycles of edge lag
    initial
    forever
    begin
        @(negedge rx);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            sh[i] = rx;
        end
        repeat (BIT) @(posedge clk);
        if (rx === 1'h1)
            got.push_back(sh);
    end
endmodule
`default_nettype wire

//--- verif/serial_port_test.sv
// Self-checking bench for the host serial port
`default_nettype none
module serial_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, backup = 0;
    logic msg_valid = 0, rx_ready = 0;
    logic [7:0] msg_data = 8'h00;
    wire logic ser_out, ser_in, msg_ready, rx_valid, pulse, operating, warm;
    wire logic [7:0] rx_data;
    wire logic [1:0] mode;
    int err_count = 0, cmp_count = 0;
    always #25 clk = ~clk;
    // Short counts keep the run small; expectations follow them
    // Periodic intervals follow the 100-cycle period; host bit time is 16
    serial_port #(.BIT_CYCLES(16), .PULSE_CYCLES(20), .PERIOD_CYCLES(100))
        i_dut (.CLK(clk), .RST_N(rst_n),
        .MODULE_SERIAL_IN(ser_in), .MODULE_SERIAL_OUT(ser_out),
        .BACKUP_SUPPLY_IN(backup),
        .EXTERNAL_EVENT_IN(),
        .MSG_VALID(msg_valid), .MSG_READY(msg_ready), .MSG_DATA(msg_data),
        .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data),
        .TIME_PULSE_OUT(pulse), .POWER_MODE(mode), .OPERATING(operating),
        .WARM_START(warm));
    host_uart i_host (.clk(clk), .rx(ser_out), .tx(ser_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rst(input logic b);
        backup <= b;
        rst_n <= 1'h0;
        repeat (6) @(posedge clk);
        chk(8'({ser_out, pulse, mode, rx_valid, msg_ready}), 8'h21);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        chk(8'(warm), 8'(b));
    endtask
    task automatic tx(input logic [7:0] b);
        msg_data <= b;
        msg_valid <= 1'h1;
        do @(posedge clk); while (msg_ready !== 1'h1);
        msg_valid <= 1'h0;
        @(posedge clk);
    endtask
    task automatic pop(input logic [7:0] e);
        while (rx_valid !== 1'h1)
            @(posedge clk);
        chk(rx_data, e);
        rx_ready <= 1'h1;
        @(posedge clk);
        rx_ready <= 1'h0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] b, input logic [7:0] m);
        i_host.send(b);
        pop(b);
        repeat (4) @(posedge clk);
        chk(8'(mode), m);
    endtask
    task automatic t_pulse;
        int n;
        // Start from a low phase so a pulse already running is not counted
        while (pulse === 1'h1)
            @(posedge clk);
        while (pulse !== 1'h1)
            @(posedge clk);
        for (n = 0; pulse === 1'h1; n++)
            @(posedge clk);
        chk(n[7:0], 8'h14);
        for (; pulse !== 1'h1; n++)
            @(posedge clk);
        chk(n[7:0], 8'h64);
    endtask
    task automatic t_tx;
        fork
            i_host.send(8'h3c);
            begin
                tx(8'h5a);
                tx(8'ha5);
            end
        join
        pop(8'h3c);
        repeat (200) @(posedge clk);
        chk(i_host.got.pop_front(), 8'h5a);
        chk(i_host.got.pop_front(), 8'ha5);
    endtask
    task automatic t_fifo;
        i_host.send(8'h10);
        i_host.send(8'h20);
        i_host.send(8'h30);
        repeat (40) @(posedge clk);
        pop(8'h10);
        pop(8'h20);
        chk(8'(rx_valid), 8'h00);
    endtask
    task automatic t_duty;
        int hi;
        hi = 0;
        repeat (200)
        begin
            @(posedge clk);
            hi += (operating === 1'h1);
        end
        chk(8'(hi > 0 && hi < 200), 8'h01);
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        conclude;
    end
    initial
    begin
        rst(1'h0);
        t_pulse;
        t_tx;
        t_fifo;
        cmd(8'h01, 8'h01);
        chk(8'({operating, msg_ready}), 8'h00);
        cmd(8'h55, 8'h00);
        cmd(8'h02, 8'h02);
        t_duty;
        cmd(8'h03, 8'h03);
        t_duty;
        cmd(8'h04, 8'h00);
        rst(1'h1);
        conclude;
    end
endmodule
`default_nettype wire
